// ### src/fwp_regs.v
// Flash write protect register bank: mode control, guarded command and
// status registers with the four-store unlock sequence.
// Assumes every peripheral store appears on this bus as one bus_wr cycle.
`timescale 1ns/1ps
`include "fwp_defines.vh"

// Contract
// - Mode register resets 08H, 0CH on-board
// - Bit 2 mirrors pin, bits 7-4 zero
// - Write/erase only when disable 0, pin 1
// - Mode 00 normal, 01 self-program, 1x prohibited
// - On-board mode ignores mode select bits
// - Upper select bit picks firmware address
// - Key, value, inverse, value; last commits
// - Command register write-only, byte, undefined
// - Mode register takes bit and byte stores
// - Violation keeps mode, sets error flag
// - Error flag sticky, cleared by writing 0
// - Status resets 00H, bit and byte stores
// - Foreign store mid-sequence aborts with error
// - Bad inverse or mismatch sets error
// - Command write without key value errors
module fwp_regs (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Mode pins
  input wire onboard_mode,
  input wire flash_mode_pin,
  // Peripheral register bus
  input wire [15:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire bus_bit,
  input wire [2:0] bus_bit_sel,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata,
  // Flash address sources
  input wire [15:0] cpu_addr,
  input wire [15:0] fw_addr,
  // Flash controls
  output wire write_erase_enable,
  output wire self_prog_active,
  output wire mode_prohibited,
  output wire addr_from_firmware,
  output wire [15:0] flash_addr,
  // Guard state
  output reg guard_error_flag,
  output reg guard_seq_busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequence states
  localparam [1:0] ST_IDLE = 2'b00; // Awaiting key
  localparam [1:0] ST_KEY = 2'b01; // Key seen
  localparam [1:0] ST_VAL = 2'b10; // First value held
  localparam [1:0] ST_INV = 2'b11; // Inverse checked

  // Reset images, so single bits are picked out at their own width
  localparam [7:0] MODE_RST = `FWP_MODE_RST;
  localparam [7:0] STAT_RST = `FWP_STAT_RST;

  // Merge a single-bit store into a current byte, or pass a byte store
  function [7:0] fwp_merge;
    input [7:0] cur;
    input is_bit;
    input [2:0] sel;
    input [7:0] wd;
    reg [7:0] tmp;
    begin
      tmp = cur;
      if (is_bit) begin
        tmp[sel] = wd[0];
      end else begin
        tmp = wd;
      end
      fwp_merge = tmp;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Storage
  reg [1:0] state; // Sequence tracker
  reg [7:0] held_value; // Value from step two
  reg write_disable; // Write/erase disable bit
  reg sel_hi; // Upper mode select bit
  reg sel_lo; // Lower mode select bit
  reg pin_level; // Sampled flash mode pin

  // Next values
  reg [1:0] next_state;
  reg [7:0] next_held_value;
  reg next_commit;
  reg next_error;

  // Decoded strobes
  wire wr_cmd;
  wire wr_mode;
  wire wr_stat;
  wire [7:0] mode_view;
  wire [7:0] mode_store;
  wire [7:0] stat_store;

  assign wr_cmd = bus_wr & (bus_addr == `FWP_ADDR_CMD);
  assign wr_mode = bus_wr & (bus_addr == `FWP_ADDR_MODE);
  assign wr_stat = bus_wr & (bus_addr == `FWP_ADDR_STAT);

  // Pin mirror in bit 2, upper nibble zero
  assign mode_view = {4'h0, write_disable, pin_level, sel_hi, sel_lo};

  // Bit stores merge into current view
  assign mode_store = fwp_merge(mode_view, bus_bit, bus_bit_sel, bus_wdata);
  assign stat_store = fwp_merge({7'h00, guard_error_flag}, bus_bit, bus_bit_sel, bus_wdata);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequence tracker decision for the current store
  always @* begin
    next_state = state;
    next_held_value = held_value;
    next_commit = 1'b0;
    next_error = 1'b0;
    if (bus_wr) begin
      case (state)
        ST_IDLE: begin
          if (wr_cmd) begin
            if (bus_wdata == `FWP_KEY) begin
              next_state = ST_KEY;
            end else begin
              next_error = 1'b1;
            end
          end else if (wr_mode) begin
            next_error = 1'b1;
          end
        end
        ST_KEY: begin
          if (wr_mode) begin
            next_held_value = mode_store;
            next_state = ST_VAL;
          end else begin
            next_error = 1'b1;
            next_state = ST_IDLE;
          end
        end
        ST_VAL: begin
          if (wr_mode && (mode_store == ~held_value)) begin
            next_state = ST_INV;
          end else begin
            next_error = 1'b1;
            next_state = ST_IDLE;
          end
        end
        ST_INV: begin
          // Step four must match step two
          if (wr_mode && (mode_store == held_value)) begin
            next_commit = 1'b1;
          end else begin
            next_error = 1'b1;
          end
          // Back to idle after either outcome
          next_state = ST_IDLE;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tracker and held value
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      held_value <= 8'h00;
      guard_seq_busy <= 1'b0;
    end else begin
      // Idle after each change forces fresh key
      state <= next_state;
      held_value <= next_held_value;
      guard_seq_busy <= (next_state != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode control register; pin bit is sampled, never stored by software
  always @(posedge clk) begin
    if (rst) begin
      // Reset to 08H, pin adds bit 2
      write_disable <= MODE_RST[`FWP_BIT_WED];
      sel_hi <= MODE_RST[`FWP_BIT_MHI];
      sel_lo <= MODE_RST[`FWP_BIT_MLO];
      pin_level <= 1'b0;
    end else begin
      pin_level <= flash_mode_pin;
      if (next_commit) begin
        write_disable <= held_value[`FWP_BIT_WED];
        sel_hi <= held_value[`FWP_BIT_MHI];
        sel_lo <= held_value[`FWP_BIT_MLO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status register: sticky protection error
  always @(posedge clk) begin
    if (rst) begin
      guard_error_flag <= STAT_RST[`FWP_BIT_ERR];
    end else if (next_error) begin
      // Set wins over a same-cycle clear
      guard_error_flag <= 1'b1;
    end else if (wr_stat && !stat_store[`FWP_BIT_ERR]) begin
      guard_error_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port, one cycle latency; unmapped and write-only read as zero
  always @(posedge clk) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      case (bus_addr)
        `FWP_ADDR_MODE: begin
          bus_rdata <= mode_view;
        end
        `FWP_ADDR_STAT: begin
          bus_rdata <= {7'h00, guard_error_flag};
        end
        `FWP_ADDR_CMD: begin
          bus_rdata <= 8'h00;
        end
        default: begin
          bus_rdata <= 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flash control decode; outputs are flops inside the decoder
  fwp_mode_decode u_decode (
    .clk(clk),
    .rst(rst),
    .mode_value(mode_view),
    .onboard_mode(onboard_mode),
    .cpu_addr(cpu_addr),
    .fw_addr(fw_addr),
    .write_erase_enable(write_erase_enable),
    .self_prog_active(self_prog_active),
    .mode_prohibited(mode_prohibited),
    .addr_from_firmware(addr_from_firmware),
    .flash_addr(flash_addr)
  );

endmodule

// ### src/fwp_defines.vh
// Constants for the flash write protect register bank.
// Assumes a 16-bit peripheral address space and an 8-bit data bus.
`ifndef FWP_DEFINES_VH
`define FWP_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register addresses
`define FWP_ADDR_CMD 16'hffc0
`define FWP_ADDR_MODE 16'hffc4
`define FWP_ADDR_STAT 16'hffc2

////////////////////////////////////////////////////////////////////////////////
// Key, reset values and masks
`define FWP_KEY 8'ha5
`define FWP_MODE_RST 8'h08
`define FWP_STAT_RST 8'h00
`define FWP_MODE_WMASK 8'h0b
`define FWP_FW_ENTRY 16'h8100

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define FWP_BIT_WED 3
`define FWP_BIT_PIN 2
`define FWP_BIT_MHI 1
`define FWP_BIT_MLO 0
`define FWP_BIT_ERR 0

`endif

// ### src/fwp_mode_decode.v
// Mode decode: turns the committed mode control value into flash controls.
// Assumes the mode value already carries the sampled pin level in its bit 2.
`timescale 1ns/1ps
`include "fwp_defines.vh"

module fwp_mode_decode (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Mode inputs
  input wire [7:0] mode_value,
  input wire onboard_mode,
  // Address sources
  input wire [15:0] cpu_addr,
  input wire [15:0] fw_addr,
  // Registered controls
  output reg write_erase_enable,
  output reg self_prog_active,
  output reg mode_prohibited,
  output reg addr_from_firmware,
  output reg [15:0] flash_addr
);

  // Effective mode bits, forced to normal in on-board mode
  wire eff_hi;
  wire eff_lo;

  assign eff_hi = mode_value[`FWP_BIT_MHI] & ~onboard_mode;
  assign eff_lo = mode_value[`FWP_BIT_MLO] & ~onboard_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Registered decode, one cycle behind the mode register
  always @(posedge clk) begin
    if (rst) begin
      write_erase_enable <= 1'b0;
      self_prog_active <= 1'b0;
      mode_prohibited <= 1'b0;
      addr_from_firmware <= 1'b0;
      flash_addr <= 16'h0000;
    end else begin
      // Enable needs disable clear, pin high
      write_erase_enable <= ~mode_value[`FWP_BIT_WED] & mode_value[`FWP_BIT_PIN];
      self_prog_active <= ~eff_hi & eff_lo;
      mode_prohibited <= eff_hi;
      addr_from_firmware <= eff_hi;
      if (eff_hi) begin
        flash_addr <= fw_addr;
      end else begin
        flash_addr <= cpu_addr;
      end
    end
  end

endmodule

// ### tb/fwp_regs_properties.sv
// Checker for the flash write protect bank.
// Sees only the top-level ports of fwp_regs; one store per bus_wr.
`timescale 1ns/1ps
`include "fwp_defines.vh"
module fwp_regs_properties (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Pins and bus
  input wire onboard_mode,
  input wire flash_mode_pin,
  input wire [15:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire bus_bit,
  input wire [7:0] bus_wdata,
  input wire [7:0] bus_rdata,
  input wire [15:0] cpu_addr,
  input wire [15:0] fw_addr,
  // Outputs under watch
  input wire write_erase_enable,
  input wire self_prog_active,
  input wire mode_prohibited,
  input wire addr_from_firmware,
  input wire [15:0] flash_addr,
  input wire guard_error_flag,
  input wire guard_seq_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Key store opening a sequence
  sequence key_s;
    bus_wr && bus_addr == `FWP_ADDR_CMD && bus_wdata == `FWP_KEY && !guard_seq_busy;
  endsequence
  // Any mode register store
  sequence mstore_s;
    bus_wr && bus_addr == `FWP_ADDR_MODE;
  endsequence
  unlock_done_a: assert property (key_s ##1 mstore_s [*3] |=> !guard_seq_busy)
    else $error("tracker not idle after four steps");
  idle_store_a: assert property (!guard_seq_busy && bus_wr && bus_addr == `FWP_ADDR_MODE
    |=> guard_error_flag)
    else $error("unguarded mode store not flagged");
  bad_key_a: assert property (!guard_seq_busy && bus_wr && bus_addr == `FWP_ADDR_CMD
    && bus_wdata != `FWP_KEY |=> guard_error_flag) else $error("wrong key not flagged");
  foreign_abort_a: assert property (guard_seq_busy && bus_wr
    && bus_addr != `FWP_ADDR_MODE |=> guard_error_flag && !guard_seq_busy)
    else $error("foreign store did not abort");
  flag_sticky_a: assert property (guard_error_flag
    && !(bus_wr && bus_addr == `FWP_ADDR_STAT) |=> guard_error_flag)
    else $error("error flag dropped by itself");
  flag_clear_a: assert property (bus_wr && bus_addr == `FWP_ADDR_STAT && !bus_bit
    && bus_wdata == 8'h00 && !guard_seq_busy |=> !guard_error_flag)
    else $error("error flag not cleared");
  onboard_quiet_a: assert property ($past(onboard_mode)
    |-> !self_prog_active && !addr_from_firmware && !mode_prohibited)
    else $error("mode select acted in on-board mode");
  enable_pin_a: assert property (write_erase_enable |-> $past(flash_mode_pin, 2))
    else $error("write enabled with pin low");
  addr_source_a: assert property (!$past(rst) && $stable(addr_from_firmware)
    && $stable(cpu_addr) && $stable(fw_addr)
    |-> flash_addr == (addr_from_firmware ? fw_addr : cpu_addr))
    else $error("flash address from wrong source");
  mode_read_a: assert property (bus_rd && bus_addr == `FWP_ADDR_MODE && !$past(rst)
    |=> bus_rdata[7:4] == 4'h0 && bus_rdata[2] == $past(flash_mode_pin, 2))
    else $error("mode read shows wrong fixed bits");
endmodule

// ### tb/tb_fwp_regs.sv
// Bench for the flash write protect bank.
// Drives the peripheral store and read strobes directly.
`timescale 1ns/1ps
`include "fwp_defines.vh"
module tb_fwp_regs;
  // Clock, reset, pins
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg onboard_mode = 1'b0;
  reg flash_mode_pin = 1'b0;
  // Register bus
  reg [15:0] bus_addr = 16'h0000;
  reg bus_wr = 1'b0;
  reg bus_rd = 1'b0;
  reg bus_bit = 1'b0;
  reg [2:0] bus_bit_sel = 3'h0;
  reg [7:0] bus_wdata = 8'h00;
  wire [7:0] bus_rdata;
  // Distinct sources so a wrong pick shows
  reg [15:0] cpu_addr = 16'h1234;
  reg [15:0] fw_addr = `FWP_FW_ENTRY;
  // Decoded controls and guard state
  wire write_erase_enable, self_prog_active, mode_prohibited, addr_from_firmware;
  wire [15:0] flash_addr;
  wire guard_error_flag, guard_seq_busy;
  integer fail_count = 0;
  integer n_compared = 0;
  integer i, k;
  reg [7:0] v;
  fwp_regs u_dut (
    .clk(clk),
    .rst(rst),
    .onboard_mode(onboard_mode),
    .flash_mode_pin(flash_mode_pin),
    .bus_addr(bus_addr),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_bit(bus_bit),
    .bus_bit_sel(bus_bit_sel),
    .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata),
    .cpu_addr(cpu_addr),
    .fw_addr(fw_addr),
    .write_erase_enable(write_erase_enable),
    .self_prog_active(self_prog_active),
    .mode_prohibited(mode_prohibited),
    .addr_from_firmware(addr_from_firmware),
    .flash_addr(flash_addr),
    .guard_error_flag(guard_error_flag),
    .guard_seq_busy(guard_seq_busy)
  );
  always #2.5 clk = ~clk;
  ////////////////////////////////////////
  // Compare and count
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Verdict, the only exit
  task results;
    begin
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // One store; strobe stays up so stores can run back to back
  task st(input [15:0] a, input [7:0] d, input b = 1'b0, input [2:0] s = 3'h0);
    begin
      @(posedge clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      bus_bit <= b;
      bus_bit_sel <= s;
    end
  endtask
  // Drop the strobe, wait for the tracker with a bound
  task idle;
    begin
      @(posedge clk);
      bus_wr <= 1'b0;
      k = 0;
      // Look once the edge has settled, not in its own time step
      #1;
      while (guard_seq_busy !== 1'b0 && k < 8) begin
        @(posedge clk);
        #1;
        k = k + 1;
      end
      if (guard_seq_busy !== 1'b0) begin
        fail_count = fail_count + 1;
        results;
      end
    end
  endtask
  // Read; data lands on the taking edge and is checked 1 ns after it
  task rd(input string nm, input [15:0] a, input [7:0] e);
    begin
      @(posedge clk);
      bus_wr <= 1'b0;
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 chk(nm, bus_rdata, e);
    end
  endtask
  // Full guarded update
  task unlock(input [7:0] x);
    begin
      // Selects move only through this guarded path
      st(`FWP_ADDR_CMD, `FWP_KEY);
      st(`FWP_ADDR_MODE, x);
      st(`FWP_ADDR_MODE, ~x);
      st(`FWP_ADDR_MODE, x);
      idle;
    end
  endtask
  // Flag set, mode kept, then cleared by a byte store
  task err(input [7:0] m);
    begin
      idle;
      rd("status", `FWP_ADDR_STAT, 8'h01);
      rd("mode", `FWP_ADDR_MODE, m);
      st(`FWP_ADDR_STAT, 8'h00);
      rd("status", `FWP_ADDR_STAT, 8'h00);
    end
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd("mode", `FWP_ADDR_MODE, 8'h08);
    rd("status", `FWP_ADDR_STAT, 8'h00);
    rd("command", `FWP_ADDR_CMD, 8'h00);
    @(posedge clk) flash_mode_pin <= 1'b1;
    rd("mode", `FWP_ADDR_MODE, 8'h0c);
    // Last code 0c leaves normal mode with writes disabled
    // Every select code; pin high so bit 2 matches
    for (i = 0; i < 5; i = i + 1) begin
      v = (i == 4) ? 8'h0c : 8'h04 + i[7:0];
      unlock(v);
      rd("mode", `FWP_ADDR_MODE, v);
      rd("status", `FWP_ADDR_STAT, 8'h00);
      chk("enable", write_erase_enable, !v[3]);
      chk("self", self_prog_active, v[1:0] == 2'b01);
      chk("prohibit", mode_prohibited, v[1]);
      chk("address", flash_addr, v[1] ? fw_addr : cpu_addr);
      chk("fwsource", addr_from_firmware, v[1]);
    end
    unlock(8'h05);
    @(posedge clk) flash_mode_pin <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("enable", write_erase_enable, 1'b0);
    @(posedge clk) flash_mode_pin <= 1'b1;
    @(posedge clk) onboard_mode <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("self", self_prog_active, 1'b0);
    chk("enable", write_erase_enable, 1'b1);
    @(posedge clk) onboard_mode <= 1'b0;
    // Violations, mode must stay 05
    st(`FWP_ADDR_MODE, 8'h0d);
    err(8'h05);
    st(`FWP_ADDR_CMD, 8'h5a);
    err(8'h05);
    st(`FWP_ADDR_CMD, `FWP_KEY);
    st(`FWP_ADDR_MODE, 8'h0d);
    st(`FWP_ADDR_MODE, 8'h0d);
    st(`FWP_ADDR_MODE, 8'h0d);
    err(8'h05);
    st(`FWP_ADDR_CMD, `FWP_KEY);
    st(`FWP_ADDR_MODE, 8'h0d);
    st(`FWP_ADDR_STAT, 8'h00);
    st(`FWP_ADDR_MODE, 8'hf2);
    st(`FWP_ADDR_MODE, 8'h0d);
    err(8'h05);
    // Sticky across errors, then single-bit clear
    st(`FWP_ADDR_MODE, 8'h0d);
    st(`FWP_ADDR_MODE, 8'h0d);
    idle;
    repeat (4) @(posedge clk);
    rd("status", `FWP_ADDR_STAT, 8'h01);
    st(`FWP_ADDR_STAT, 8'h00, 1'b1, 3'h0);
    rd("status", `FWP_ADDR_STAT, 8'h00);
    // Guarded update with single-bit stores on steps two and four
    st(`FWP_ADDR_CMD, `FWP_KEY);
    st(`FWP_ADDR_MODE, 8'h01, 1'b1, 3'h3);
    st(`FWP_ADDR_MODE, 8'hf2);
    st(`FWP_ADDR_MODE, 8'h01, 1'b1, 3'h3);
    idle;
    rd("mode", `FWP_ADDR_MODE, 8'h0d);
    rd("status", `FWP_ADDR_STAT, 8'h00);
    // Second reset in on-board mode, pin high: mode reads 0c
    @(posedge clk) onboard_mode <= 1'b1;
    @(posedge clk) rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd("mode", `FWP_ADDR_MODE, 8'h0c);
    rd("status", `FWP_ADDR_STAT, 8'h00);
    chk("enable", write_erase_enable, 1'b0);
    chk("self", self_prog_active, 1'b0);
    results;
  end
endmodule
bind fwp_regs fwp_regs_properties u_chk (
  .clk(clk),
  .rst(rst),
  .onboard_mode(onboard_mode),
  .flash_mode_pin(flash_mode_pin),
  .bus_addr(bus_addr),
  .bus_wr(bus_wr),
  .bus_rd(bus_rd),
  .bus_bit(bus_bit),
  .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata),
  .cpu_addr(cpu_addr),
  .fw_addr(fw_addr),
  .write_erase_enable(write_erase_enable),
  .self_prog_active(self_prog_active),
  .mode_prohibited(mode_prohibited),
  .addr_from_firmware(addr_from_firmware),
  .flash_addr(flash_addr),
  .guard_error_flag(guard_error_flag),
  .guard_seq_busy(guard_seq_busy)
);
